// *** src/ssl_consts.vh ***
`ifndef SSL_CONSTS_VH
`define SSL_CONSTS_VH
// ------------------------------------------------------------
// Register word indices (byte address = index * 4)
// ------------------------------------------------------------
`define SSL_IDX_LIMITS 6'h01
`define SSL_IDX_CLAMPS 6'h02
`define SSL_IDX_CAPTURE 6'h04
`define SSL_IDX_CTRL 6'h10
`define SSL_IDX_EXTENDED_ERROR_REG 6'h11
`define SSL_IDX_ANGLE 6'h12
// ------------------------------------------------------------
// Field positions and widths
// ------------------------------------------------------------
`define SSL_HI_MSB 31
`define SSL_HI_LSB 16
`define SSL_LO_MSB 15
`define SSL_LO_LSB 0
`define SSL_PAD_W 4
`define SSL_NVM_W 12
`define SSL_CTRL_EN_BIT 0
`define SSL_CTRL_LOAD_BIT 1
`define SSL_EXTENDED_ERROR_REG_OVER_BIT 0
`define SSL_EXTENDED_ERROR_REG_UNDER_BIT 1
// ------------------------------------------------------------
// Values
// ------------------------------------------------------------
`define SSL_ZERO16 16'h0000
`define SSL_CEIL_FORCED 16'hfff0
`define SSL_HAR_LIMIT_MAX 4'h9
`define SSL_HAR_CLAMP_MAX 4'ha
`define SSL_PAD4 4'h0
`define SSL_ZERO32 32'h0000_0000
`endif

// *** src/ssl_nvm_loader.v ***
`timescale 1ns/1ps
`include "ssl_consts.vh"
// ------------------------------------------------------------
// Expands a 12-bit stored field to a 16-bit volatile value
// ------------------------------------------------------------
module ssl_nvm_loader (
   // Stored values
   input wire [11:0] nvm_upper_i,
   input wire [11:0] nvm_lower_i,
   // Forcing controls
   input wire force_zero_i,
   input wire force_ceiling_i,
   // Expanded word
   output reg [31:0] word_o
);
   // Upper half uses top bits, lower half is shifted left, pads zero
   always @* begin
      word_o = {nvm_upper_i, `SSL_PAD4, nvm_lower_i, `SSL_PAD4}; // RL13 RL14
      if (force_zero_i) begin
         word_o = `SSL_ZERO32; // RL16
      end
      if (force_ceiling_i) begin
         word_o = {`SSL_CEIL_FORCED, `SSL_ZERO16}; // RL17
      end
   end
endmodule // ssl_nvm_loader

// *** src/ssl_angle_check.v ***
`timescale 1ns/1ps
`include "ssl_consts.vh"
// ------------------------------------------------------------
// Combinational limit test and clamp of one sample
// ------------------------------------------------------------
module ssl_angle_check (
   // Sample
   input wire [15:0] raw_angle_i,
   input wire [15:0] proc_angle_i,
   input wire enable_i,
   // Settings
   input wire [31:0] limits_i,
   input wire [31:0] clamps_i,
   // Results
   output reg over_o,
   output reg under_o,
   output reg [15:0] out_angle_o
);
   wire [15:0] upper = limits_i[`SSL_HI_MSB:`SSL_HI_LSB];
   wire [15:0] lower = limits_i[`SSL_LO_MSB:`SSL_LO_LSB];
   wire [15:0] ceil_v = clamps_i[`SSL_HI_MSB:`SSL_HI_LSB];
   wire [15:0] floor_v = clamps_i[`SSL_LO_MSB:`SSL_LO_LSB];
   // Unsigned compares; zero limit disables its check
   always @* begin
      over_o = enable_i && (upper != `SSL_ZERO16) && (raw_angle_i > upper); // RL1 RL2 RL4 RL5 RL20
      under_o = enable_i && (lower != `SSL_ZERO16) && (raw_angle_i < lower); // RL3 RL6 RL20
      out_angle_o = proc_angle_i;
      if (enable_i) begin
         // Final clamp of processed angle
         if (proc_angle_i > ceil_v) begin
            out_angle_o = ceil_v; // RL9 RL11
         end else if (proc_angle_i < floor_v) begin
            out_angle_o = floor_v; // RL10 RL11
         end
         // Limit violations override with clamp values
         if (over_o) begin
            out_angle_o = ceil_v; // RL7
         end else if (under_o) begin
            out_angle_o = floor_v; // RL8
         end
      end
   end
endmodule // ssl_angle_check

// *** src/ssl_limit_clamp.v ***
`timescale 1ns/1ps
`include "ssl_consts.vh"
// Contract
// RL1: Compare raw angle after rotation and offset
// RL2: Raw above upper limit sets over flag
// RL3: Raw below lower limit sets under flag
// RL4: Checks and clamping only when enabled
// RL5: Upper limit zero disables maximum check
// RL6: Lower limit zero disables minimum check
// RL7: Over violation outputs the ceiling value
// RL8: Under violation outputs the floor value
// RL9: Processed angle above ceiling is clamped
// RL10: Processed angle below floor is clamped
// RL11: Clamp values are unsigned 16-bit angles
// RL12: Host disables clamping with ffff and zero
// RL13: Upper halves load from NVM, low pad
// RL14: Lower halves load shifted, low pad
// RL15: All sixteen bits writable and readable
// RL16: Harmonic count above nine zeroes limits
// RL17: Harmonic count above ten forces clamp
// RL18: Flags are bits of extended error register
// RL19: Violation captures unclamped angle
// RL20: Unsigned compares once per sample
module ssl_limit_clamp (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [7:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   // Angle stream
   input wire sample_valid_i,
   input wire [15:0] raw_angle_i,
   input wire [15:0] proc_angle_i,
   output reg angle_valid_o,
   output reg [15:0] angle_o,
   // Non-volatile values
   input wire nvm_load_i,
   input wire [11:0] nvm_upper_limit_i,
   input wire [11:0] nvm_lower_limit_i,
   input wire [11:0] nvm_ceiling_i,
   input wire [11:0] nvm_floor_i,
   input wire [3:0] nvm_har_count_i,
   // Error flags
   output reg angle_over_flag_o,
   output reg angle_under_flag_o
);
   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   reg [31:0] limits_q; // Input angle limits
   reg [31:0] clamps_q; // Output ceiling and floor
   reg [15:0] capture_q; // Captured violation angle
   reg enable_q; // Short-stroke enable
   reg load_req_q; // Software load request
   reg [31:0] rd_d; // Read mux
   wire [31:0] lim_nvm; // Expanded limit word
   wire [31:0] clp_nvm; // Expanded clamp word
   wire over; // Over-range this sample
   wire under; // Under-range this sample
   wire [15:0] out_angle; // Checked angle
   wire bus_req = cyc_i && stb_i && !ack_o; // New access
   wire bus_wr = bus_req && we_i; // Write access
   wire [5:0] idx = adr_i[7:2]; // Word index
   wire do_load = nvm_load_i || load_req_q; // Load strobe
   // Byte-lane merge of a write into a word
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] sel;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (sel[k]) begin
               merge[k*8 +: 8] = nw[k*8 +: 8];
            end
         end
      end
   endfunction
   // ------------------------------------------------------------
   // Sub-blocks
   // ------------------------------------------------------------
   ssl_nvm_loader u_lim_load (
      .nvm_upper_i(nvm_upper_limit_i),
      .nvm_lower_i(nvm_lower_limit_i),
      .force_zero_i(nvm_har_count_i > `SSL_HAR_LIMIT_MAX),
      .force_ceiling_i(1'b0),
      .word_o(lim_nvm)
   );
   ssl_nvm_loader u_clp_load (
      .nvm_upper_i(nvm_ceiling_i),
      .nvm_lower_i(nvm_floor_i),
      .force_zero_i(1'b0),
      .force_ceiling_i(nvm_har_count_i > `SSL_HAR_CLAMP_MAX),
      .word_o(clp_nvm)
   );
   ssl_angle_check u_check (
      .raw_angle_i(raw_angle_i),
      .proc_angle_i(proc_angle_i),
      .enable_i(enable_q),
      .limits_i(limits_q),
      .clamps_i(clamps_q),
      .over_o(over),
      .under_o(under),
      .out_angle_o(out_angle)
   );
   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         limits_q <= `SSL_ZERO32;
         clamps_q <= `SSL_ZERO32;
         enable_q <= 1'b0;
         load_req_q <= 1'b0;
      end else begin
         load_req_q <= 1'b0;
         if (do_load) begin
            // Load from non-volatile values wins over writes
            limits_q <= lim_nvm; // RL13 RL14 RL16
            clamps_q <= clp_nvm; // RL17
         end else if (bus_wr && idx == `SSL_IDX_LIMITS) begin
            limits_q <= merge(limits_q, dat_i, sel_i); // RL15
         end else if (bus_wr && idx == `SSL_IDX_CLAMPS) begin
            clamps_q <= merge(clamps_q, dat_i, sel_i); // RL15 RL12
         end
         if (bus_wr && idx == `SSL_IDX_CTRL && sel_i[0]) begin
            enable_q <= dat_i[`SSL_CTRL_EN_BIT];
            load_req_q <= dat_i[`SSL_CTRL_LOAD_BIT];
         end
      end
   end
   // ------------------------------------------------------------
   // Sample processing and error flags
   // ------------------------------------------------------------
   // Flags are sticky; writing one to the error word clears them,
   // but a violation in the same cycle keeps the flag set.
   always @(posedge clk_i) begin
      if (rst_i) begin
         angle_over_flag_o <= 1'b0;
         angle_under_flag_o <= 1'b0;
         capture_q <= `SSL_ZERO16;
         angle_o <= `SSL_ZERO16;
         angle_valid_o <= 1'b0;
      end else begin
         angle_valid_o <= sample_valid_i;
         if (bus_wr && idx == `SSL_IDX_EXTENDED_ERROR_REG && sel_i[0]) begin
            if (dat_i[`SSL_EXTENDED_ERROR_REG_OVER_BIT]) begin
               angle_over_flag_o <= 1'b0;
            end
            if (dat_i[`SSL_EXTENDED_ERROR_REG_UNDER_BIT]) begin
               angle_under_flag_o <= 1'b0;
            end
         end
         if (sample_valid_i) begin
            angle_o <= out_angle; // RL20
            if (over) begin
               angle_over_flag_o <= 1'b1; // RL2 RL18
            end
            if (under) begin
               angle_under_flag_o <= 1'b1; // RL3 RL18
            end
            if (over || under) begin
               capture_q <= raw_angle_i; // RL19
            end
         end
      end
   end
   // ------------------------------------------------------------
   // Bus read mux and acknowledge
   // ------------------------------------------------------------
   always @* begin
      rd_d = `SSL_ZERO32;
      case (idx)
         `SSL_IDX_LIMITS: rd_d = limits_q;
         `SSL_IDX_CLAMPS: rd_d = clamps_q;
         `SSL_IDX_CAPTURE: rd_d = {`SSL_ZERO16, capture_q};
         `SSL_IDX_CTRL: rd_d = {31'h0000_0000, enable_q};
         `SSL_IDX_EXTENDED_ERROR_REG: rd_d = {30'h0000_0000, angle_under_flag_o, angle_over_flag_o};
         `SSL_IDX_ANGLE: rd_d = {`SSL_ZERO16, angle_o};
         default: rd_d = `SSL_ZERO32;
      endcase
   end
   // One-cycle answer; unmapped reads return zero
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= `SSL_ZERO32;
      end else begin
         ack_o <= bus_req;
         if (bus_req && !we_i) begin
            dat_o <= rd_d;
         end
      end
   end
endmodule // ssl_limit_clamp

// *** test/ssl_host.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Host model: classic Wishbone master
// ----------------------------------------
module ssl_host (
   // Clock
   input wire clk_i,
   // Bus
   output reg cyc_o,
   output reg stb_o,
   output reg we_o,
   output reg [7:0] adr_o,
   output reg [3:0] sel_o,
   output reg [31:0] dat_o,
   input wire [31:0] dat_i,
   input wire ack_i,
   // Hang flag
   output reg tmo_o
);
   integer n;
   initial begin
      {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o, tmo_o} = 0;
   end
   // Request held until ack is sampled, then released with scrambled lines
   task xfer(input w, input [7:0] a, input [3:0] s, input [31:0] d, output [31:0] q);
      begin
         @(posedge clk_i);
         {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, s, d};
         n = 0;
         do begin
            @(posedge clk_i);
            n = n + 1;
         end while (ack_i !== 1'b1 && n < 16);
         if (ack_i !== 1'b1) tmo_o <= 1'b1;
         q = dat_i;
         {cyc_o, stb_o, we_o, adr_o, dat_o} <= {3'b000, ~a, ~d};
      end
   endtask
endmodule // ssl_host

// *** test/ssl_limit_clamp_chk.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module ssl_chk (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Watched ports
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire ack_o,
   input wire sample_valid_i,
   input wire angle_valid_o,
   input wire [15:0] angle_o,
   input wire angle_over_flag_o,
   input wire angle_under_flag_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack late");
   AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
      else $error("ack too long");
   AST_VALID_LAT: assert property (sample_valid_i |=> angle_valid_o)
      else $error("angle valid late");
   AST_ANGLE_HOLD: assert property (!sample_valid_i |=> $stable(angle_o))
      else $error("angle moved without sample");
   AST_OVER_SET: assert property ($rose(angle_over_flag_o) |-> angle_valid_o)
      else $error("over flag without sample");
   AST_UNDER_SET: assert property ($rose(angle_under_flag_o) |-> angle_valid_o)
      else $error("under flag without sample");
   // A flag cleared by reset falls one edge later, so the past reset masks it
   AST_OVER_CLR: assert property ($fell(angle_over_flag_o) && !$past(rst_i)
      |-> $past(cyc_i && stb_i && we_i && !ack_o))
      else $error("over flag lost");
   AST_UNDER_CLR: assert property ($fell(angle_under_flag_o) && !$past(rst_i)
      |-> $past(cyc_i && stb_i && we_i && !ack_o))
      else $error("under flag lost");
endmodule // ssl_chk
bind ssl_limit_clamp ssl_chk i_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .ack_o,
   .sample_valid_i, .angle_valid_o, .angle_o, .angle_over_flag_o, .angle_under_flag_o);

// *** test/tb_short_stroke_limit_clamp.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Testbench
// ----------------------------------------
module tb_short_stroke_limit_clamp;
   reg clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg sv = 1'b0;
   reg nld = 1'b0;
   reg [3:0] har = 4'h0;
   reg [15:0] raw = 16'h0000;
   reg [15:0] prc = 16'h0000;
   reg [15:0] cap = 16'h0000;
   reg [31:0] q;
   reg [50:0] rows [0:5];
   integer mismatches = 0;
   integer comparisons = 0;
   integer i;
   wire cyc, stb, we, ack, av, ovf, unf, tmo;
   wire [7:0] adr;
   wire [3:0] sel;
   wire [31:0] wd, rd;
   wire [15:0] ang;
   always #12.5 clk_i = ~clk_i;
   ssl_limit_clamp i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rd), .ack_o(ack), .sample_valid_i(sv),
      .raw_angle_i(raw), .proc_angle_i(prc), .angle_valid_o(av), .angle_o(ang),
      .nvm_load_i(nld), .nvm_upper_limit_i(12'habc), .nvm_lower_limit_i(12'h123),
      .nvm_ceiling_i(12'h456), .nvm_floor_i(12'h789), .nvm_har_count_i(har),
      .angle_over_flag_o(ovf), .angle_under_flag_o(unf));
   ssl_host i_host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
      .sel_o(sel), .dat_o(wd), .dat_i(rd), .ack_i(ack), .tmo_o(tmo));
   task chk(input [31:0] s, input [31:0] e, input string nm);
      begin
         comparisons = comparisons + 1;
         if (s !== e) begin
            mismatches = mismatches + 1;
            $display("Error %0s expected %h seen %h", nm, e, s);
         end
      end
   endtask
   task wr(input [7:0] a, input [3:0] s, input [31:0] d);
      i_host.xfer(1'b1, a, s, d, q);
   endtask
   task rdc(input [7:0] a, input [31:0] e, input string nm);
      begin
         i_host.xfer(1'b0, a, 4'hf, 32'h0, q);
         chk(q, e, nm);
      end
   endtask
   // One sample; result is checked just after the edge that takes it
   task smp(input [15:0] r, input [15:0] p, input [15:0] e);
      begin
         @(posedge clk_i);
         {sv, raw, prc} <= {1'b1, r, p};
         @(posedge clk_i);
         sv <= 1'b0;
         #1;
         chk(av, 1, "valid");
         chk(ang, e, "angle");
      end
   endtask
   task give_verdict;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, mismatches);
         if (mismatches == 0 && comparisons > 0) begin
            $display("TEST PASSED");
         end else begin
            $display("TEST FAILED");
         end
         $finish;
      end
   endtask
   always @(posedge tmo) begin
      mismatches = mismatches + 1;
      give_verdict;
   end
   initial begin
      // Rows: enable, raw, processed, expected angle, {under, over}
      rows[0] = {1'b1, 16'h9000, 16'h1234, 16'h7001, 2'b01};
      rows[1] = {1'b1, 16'h8000, 16'h7fff, 16'h7001, 2'b00};
      rows[2] = {1'b1, 16'h100e, 16'h5555, 16'h2003, 2'b10};
      rows[3] = {1'b1, 16'h100f, 16'h2002, 16'h2003, 2'b00};
      rows[4] = {1'b1, 16'h4000, 16'h3456, 16'h3456, 2'b00};
      rows[5] = {1'b0, 16'h9000, 16'h0100, 16'h0100, 2'b00};
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rdc(8'h04, 0, "limits");
      rdc(8'h40, 0, "ctrl");
      chk({ovf, unf, av}, 0, "flags");
      rdc(8'hfc, 0, "unmapped");
      wr(8'h04, 4'hf, 32'h8000_100f);
      wr(8'h08, 4'hf, 32'h7001_2003);
      rdc(8'h04, 32'h8000_100f, "limits rw");
      rdc(8'h08, 32'h7001_2003, "clamps rw");
      $display("reset and register test done");
      for (i = 0; i < 6; i = i + 1) begin
         wr(8'h40, 4'hf, {31'h0, rows[i][50]});
         smp(rows[i][49:34], rows[i][33:18], rows[i][17:2]);
         chk({unf, ovf}, rows[i][1:0], "flag pins");
         if (rows[i][1:0] != 2'b00) cap = rows[i][49:34];
         rdc(8'h44, {30'h0, rows[i][1:0]}, "extended_error_reg");
         rdc(8'h10, {16'h0, cap}, "capture");
         wr(8'h44, 4'hf, 32'h3);
      end
      $display("row test done");
      wr(8'h40, 4'hf, 32'h1);
      wr(8'h04, 4'h3, 32'hffff_0000);
      rdc(8'h04, 32'h8000_0000, "lanes");
      wr(8'h04, 4'hf, 32'h0);
      wr(8'h08, 4'hf, 32'hffff_0000);
      @(posedge clk_i);
      {sv, raw, prc} <= {1'b1, 16'hffff, 16'hfffe};
      @(posedge clk_i);
      {raw, prc} <= {16'h0000, 16'h0001};
      #1;
      chk(ang, 16'hfffe, "first");
      @(posedge clk_i);
      sv <= 1'b0;
      #1;
      chk(ang, 16'h0001, "second");
      rdc(8'h44, 0, "extended_error_reg off");
      $display("back to back test done");
      for (i = 9; i < 12; i = i + 1) begin
         @(posedge clk_i);
         {har, nld} <= {i[3:0], 1'b1};
         @(posedge clk_i);
         nld <= 1'b0;
         rdc(8'h04, (i > 9) ? 0 : 32'habc0_1230, "nvm limits");
         rdc(8'h08, (i > 10) ? 32'hfff0_0000 : 32'h4560_7890, "nvm clamps");
      end
      $display("load test done");
      // Control and last angle readback, then a reset in mid-run
      har <= 4'h0;
      wr(8'h04, 4'hf, 32'h1000_0000);
      wr(8'h40, 4'hf, 32'h1);
      rdc(8'h40, 32'h1, "ctrl rw");
      smp(16'h2000, 16'h0100, 16'hfff0);
      rdc(8'h48, 32'h0000_fff0, "last angle");
      chk({ovf, unf}, 2'b10, "over pin");
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk({ovf, unf, av, ack, ang}, 0, "reset outputs");
      chk(rd, 0, "read data after reset");
      rdc(8'h04, 0, "limits after reset");
      rdc(8'h40, 0, "ctrl after reset");
      rdc(8'h10, 0, "capture after reset");
      // Load requested through the control word
      wr(8'h40, 4'hf, 32'h2);
      rdc(8'h04, 32'habc0_1230, "sw load limits");
      rdc(8'h08, 32'h4560_7890, "sw load clamps");
      $display("reset and software load test done");
      give_verdict;
   end
endmodule // tb_short_stroke_limit_clamp
